/* File: rtl/one_shot_consts.svh */
// Behaviour
// - pulse starts on trigger false-to-true change
// - steady true trigger never retriggers
// - retriggerable mode restarts timing on edge
// - non-retriggerable mode ignores triggers during pulse
// - clear ends pulse and blocks new ones
// - output held; clear beats same-cycle trigger
// - trigger inputs of both senses provided
// - both modes work for either edge
// - retriggerable mode fine at 100% duty
// - releasing clear with true trigger no pulse
`ifndef ONE_SHOT_CONSTS_SVH
`define ONE_SHOT_CONSTS_SVH
`define OS_WIDTH_BITS 16
`define OS_POS_INPUTS 2
`define OS_NEG_INPUTS 2
`define OS_COUNT_ZERO 16'h0000
`define OS_COUNT_ONE  16'h0001
`endif

/* File: rtl/one_shot_pkg.sv */
`include "one_shot_consts.svh"
package one_shot_pkg;
	typedef logic [`OS_WIDTH_BITS-1:0] count_t;
	typedef enum logic {S_IDLE, S_PULSE} state_e;
endpackage

/* File: rtl/trigger_sync.sv */
`timescale 1ns/100ps
`include "one_shot_consts.svh"
module trigger_sync (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic [`OS_POS_INPUTS-1:0]  trigPos,
	input  wire logic [`OS_NEG_INPUTS-1:0]  trigNeg,
	input  wire logic                       clearIn,
	output logic                            trigTrue,
	output logic                            clearSync
);
	localparam int W = `OS_POS_INPUTS + `OS_NEG_INPUTS + 1;
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_stage2;
	always_comb begin
		next_stage1 = {clearIn, trigNeg, trigPos};
		next_stage2 = stage1;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
		end
	end
	// positive inputs act on high, negative on low; any one fires
	always_comb begin
		trigTrue = (|stage2[`OS_POS_INPUTS-1:0])
			| ~(&stage2[W-2:`OS_POS_INPUTS]);
		clearSync = stage2[W-1];
	end
endmodule

/* File: rtl/retriggerable_one_shot_timer.sv */
`timescale 1ns/100ps
`include "one_shot_consts.svh"
module retriggerable_one_shot_timer
	import one_shot_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic [`OS_POS_INPUTS-1:0]  trigPos,
	input  wire logic [`OS_NEG_INPUTS-1:0]  trigNeg,
	input  wire logic                       clearIn,
	input  wire logic                       retrigMode,
	input  wire logic [`OS_WIDTH_BITS-1:0]  pulseCycles,
	output logic                            pulseOut,
	output logic                            pulseOutN,
	output logic                            triggerSeen
);
	logic   trigTrue;
	logic   clearSync;
	logic   trigPrev;
	logic   next_trigPrev;
	logic   fire;
	state_e state;
	state_e next_state;
	count_t count;
	count_t next_count;
	logic   next_triggerSeen;
	logic   next_pulseOut;
	logic   next_pulseOutN;

	trigger_sync u_sync (
		.clk       (clk),
		.rst       (rst),
		.trigPos   (trigPos),
		.trigNeg   (trigNeg),
		.clearIn   (clearIn),
		.trigTrue  (trigTrue),
		.clearSync (clearSync)
	);

	// zero width refuses an edge, so a start or reload never
	// leaves a running pulse with an empty count
	function automatic logic takeEdge(input logic edgeIn,
		input count_t width);
		return edgeIn && (width != `OS_COUNT_ZERO);
	endfunction

	// previous level is tracked even under clear, so releasing clear
	// with the condition already true is not seen as an edge
	assign fire = trigTrue & ~trigPrev;

	always_comb begin
		next_trigPrev    = trigTrue;
		next_state       = state;
		next_count       = count;
		next_triggerSeen = 1'b0;
		if (clearSync) begin
			next_state = S_IDLE;
			next_count = `OS_COUNT_ZERO;
		end else begin
			case (state)
				S_IDLE: begin
					if (takeEdge(fire, pulseCycles)) begin
						next_state       = S_PULSE;
						next_count       = pulseCycles;
						next_triggerSeen = 1'b1;
					end
				end
				S_PULSE: begin
					if (takeEdge(fire, pulseCycles) && retrigMode) begin
						next_count       = pulseCycles;
						next_triggerSeen = 1'b1;
					end else if (count == `OS_COUNT_ONE) begin
						// edges in non-retrig mode just fall through
						next_state = S_IDLE;
						next_count = `OS_COUNT_ZERO;
					end else begin
						next_count = count - `OS_COUNT_ONE;
					end
				end
				default: next_state = S_IDLE;
			endcase
		end
		// outputs are own flops, so neither glitches on a state decode
		next_pulseOut  = (next_state == S_PULSE);
		next_pulseOutN = (next_state != S_PULSE);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state       <= S_IDLE;
			count       <= `OS_COUNT_ZERO;
			trigPrev    <= 1'b1;
			triggerSeen <= 1'b0;
			pulseOut    <= 1'b0;
			pulseOutN   <= 1'b1;
		end else begin
			state       <= next_state;
			count       <= next_count;
			trigPrev    <= next_trigPrev;
			triggerSeen <= next_triggerSeen;
			pulseOut    <= next_pulseOut;
			pulseOutN   <= next_pulseOutN;
		end
	end

	sequence s_fireIdle;
		fire && !clearSync && state == S_IDLE && pulseCycles != '0;
	endsequence
	sequence s_fireRetrig;
		fire && !clearSync && state == S_PULSE && retrigMode
			&& pulseCycles != '0;
	endsequence

	property p_start;
		@(posedge clk) disable iff (rst)
		s_fireIdle |=> pulseOut && count == $past(pulseCycles);
	endproperty
	a_start: assert property (p_start)
		else $error("pulse did not start on trigger edge");

	property p_noEdgeNoStart;
		@(posedge clk) disable iff (rst)
		(state == S_IDLE && !fire) |=> state == S_IDLE;
	endproperty
	a_noEdgeNoStart: assert property (p_noEdgeNoStart)
		else $error("pulse started without trigger edge");

	property p_retrig;
		@(posedge clk) disable iff (rst)
		s_fireRetrig |=> pulseOut && count == $past(pulseCycles);
	endproperty
	a_retrig: assert property (p_retrig)
		else $error("retrigger did not reload count");

	property p_noRetrig;
		@(posedge clk) disable iff (rst)
		(state == S_PULSE && !retrigMode && !clearSync && count > 1)
			|=> count == $past(count) - 1;
	endproperty
	a_noRetrig: assert property (p_noRetrig)
		else $error("non-retrig pulse disturbed by trigger");

	property p_clear;
		@(posedge clk) disable iff (rst)
		clearSync |=> !pulseOut;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear did not end pulse");

	property p_clearWins;
		@(posedge clk) disable iff (rst)
		(clearSync && fire) |=> !pulseOut && !triggerSeen;
	endproperty
	a_clearWins: assert property (p_clearWins)
		else $error("trigger beat clear");

	property p_release;
		@(posedge clk) disable iff (rst)
		($fell(clearSync) && trigTrue && $past(trigTrue)) |=> !pulseOut;
	endproperty
	a_release: assert property (p_release)
		else $error("clear release started pulse");

	property p_timeout;
		@(posedge clk) disable iff (rst)
		(pulseOut && count == 1 && !clearSync
			&& !(fire && retrigMode && pulseCycles != '0))
			|=> !pulseOut;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("pulse did not time out");

	property p_compl;
		@(posedge clk) disable iff (rst)
		pulseOutN == !pulseOut;
	endproperty
	a_compl: assert property (p_compl)
		else $error("complement output wrong");

	property p_outState;
		@(posedge clk) disable iff (rst)
		pulseOut == (state == S_PULSE);
	endproperty
	a_outState: assert property (p_outState)
		else $error("pulse output does not follow held state");

	property p_seenStart;
		@(posedge clk) disable iff (rst)
		triggerSeen |-> pulseOut && count == $past(pulseCycles);
	endproperty
	a_seenStart: assert property (p_seenStart)
		else $error("accepted trigger without loaded pulse");

	property p_seenSingle;
		@(posedge clk) disable iff (rst)
		triggerSeen |=> !triggerSeen;
	endproperty
	a_seenSingle: assert property (p_seenSingle)
		else $error("trigger accepted on two cycles in a row");

	property p_zeroWidth;
		@(posedge clk) disable iff (rst)
		(state == S_IDLE && pulseCycles == `OS_COUNT_ZERO) |=> !pulseOut;
	endproperty
	a_zeroWidth: assert property (p_zeroWidth)
		else $error("pulse started with zero width");

	property p_clearSeen;
		@(posedge clk) disable iff (rst)
		clearSync |=> !triggerSeen && count == `OS_COUNT_ZERO;
	endproperty
	a_clearSeen: assert property (p_clearSeen)
		else $error("trigger accepted under clear");

	property p_countZero;
		@(posedge clk) disable iff (rst)
		(state == S_PULSE) == (count != `OS_COUNT_ZERO);
	endproperty
	a_countZero: assert property (p_countZero)
		else $error("count and pulse state disagree");

	sequence s_steadyTrue;
		trigTrue && trigPrev;
	endsequence
	property p_steadyNoReload;
		@(posedge clk) disable iff (rst)
		(s_steadyTrue ##0 (state == S_PULSE && count > 16'h0001
			&& !clearSync)) |=> count == $past(count) - 16'h0001;
	endproperty
	a_steadyNoReload: assert property (p_steadyNoReload)
		else $error("steady trigger reloaded the count");
endmodule

/* File: sim/trigger_source.sv */
`timescale 1ns/100ps
`include "one_shot_consts.svh"
module trigger_source (
	input  wire logic                      clk,
	input  wire logic [`OS_POS_INPUTS-1:0] posReq,
	input  wire logic [`OS_NEG_INPUTS-1:0] negReq,
	input  wire logic                      clrReq,
	output logic      [`OS_POS_INPUTS-1:0] trigPos,
	output logic      [`OS_NEG_INPUTS-1:0] trigNeg,
	output logic                           clearIn
);
	// upstream flops: pins change once per cycle, never mid-cycle
	always_ff @(posedge clk) begin
		trigPos <= posReq;
		trigNeg <= negReq;
		clearIn <= clrReq;
	end
endmodule

/* File: sim/retriggerable_one_shot_timer_tb.sv */
`timescale 1ns/100ps
`include "one_shot_consts.svh"
module retriggerable_one_shot_timer_tb;
	logic                      clk = 0;
	logic                      rst = 1;
	logic                      retrigMode = 0;
	logic [`OS_POS_INPUTS-1:0] posReq = 0;
	logic [`OS_NEG_INPUTS-1:0] negReq = 2'h3;
	logic                      clrReq = 0;
	logic [`OS_WIDTH_BITS-1:0] pulseCycles = 16'h0008;
	logic [`OS_POS_INPUTS-1:0] trigPos;
	logic [`OS_NEG_INPUTS-1:0] trigNeg;
	logic                      clearIn;
	logic                      pulseOut;
	logic                      pulseOutN;
	logic                      triggerSeen;
	int                        failures = 0;
	int                        checks_done = 0;
	int                        highCount = 0;
	int                        seenCount = 0;
	always #2.5 clk = ~clk;
	trigger_source u_src (.clk(clk), .posReq(posReq), .negReq(negReq),
		.clrReq(clrReq), .trigPos(trigPos), .trigNeg(trigNeg),
		.clearIn(clearIn));
	retriggerable_one_shot_timer u_dut (.clk(clk), .rst(rst),
		.trigPos(trigPos), .trigNeg(trigNeg), .clearIn(clearIn),
		.retrigMode(retrigMode), .pulseCycles(pulseCycles),
		.pulseOut(pulseOut), .pulseOutN(pulseOutN),
		.triggerSeen(triggerSeen));
	// sampled mid-cycle so every edge update has landed
	always @(negedge clk) begin
		highCount += (pulseOut === 1'b1);
		seenCount += (triggerSeen === 1'b1);
		checks_done++;
		if ((pulseOut ^ pulseOutN) !== 1'h1) begin
			failures++;
			$display("FAIL pulseOutN exp %b got %b", ~pulseOut, pulseOutN);
		end
	end
	task drive(input logic [1:0] p, input logic [1:0] n, input logic c,
		input int k);
		@(posedge clk);
		posReq <= p;
		negReq <= n;
		clrReq <= c;
		repeat (k) @(posedge clk);
	endtask
	task result(input string what, input int expH, input int expS);
		repeat (30) @(posedge clk);
		checks_done += 2;
		if (highCount != expH || seenCount != expS) begin
			failures++;
			$display("FAIL %s exp %0d/%0d got %0d/%0d", what, expH, expS,
				highCount, seenCount);
		end
		highCount = 0;
		seenCount = 0;
	endtask
	task final_report;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		result("idle", 0, 0);
		drive(2'h1, 2'h3, 0, 40);
		drive(2'h0, 2'h3, 0, 0);
		result("steady", 8, 1);
		drive(2'h0, 2'h2, 0, 0);
		result("negSense", 8, 1);
		retrigMode <= 1;
		drive(2'h0, 2'h3, 0, 5);
		drive(2'h2, 2'h3, 0, 2);
		drive(2'h0, 2'h3, 0, 2);
		drive(2'h2, 2'h3, 0, 0);
		result("retrig", 14, 2);
		retrigMode <= 0;
		drive(2'h0, 2'h3, 0, 5);
		drive(2'h2, 2'h3, 0, 2);
		drive(2'h0, 2'h3, 0, 2);
		drive(2'h2, 2'h3, 0, 0);
		result("noRetrig", 8, 1);
		drive(2'h0, 2'h3, 0, 5);
		drive(2'h1, 2'h3, 0, 3);
		drive(2'h1, 2'h3, 1, 0);
		drive(2'h0, 2'h3, 1, 2);
		drive(2'h1, 2'h3, 1, 0);
		result("clear", 4, 1);
		drive(2'h0, 2'h3, 0, 4);
		drive(2'h1, 2'h3, 1, 3);
		drive(2'h1, 2'h3, 0, 0);
		result("clrPrio", 0, 0);
		pulseCycles <= 16'h0003;
		drive(2'h0, 2'h3, 0, 4);
		drive(2'h1, 2'h3, 0, 0);
		result("width3", 3, 1);
		pulseCycles <= 16'h0000;
		drive(2'h0, 2'h3, 0, 4);
		drive(2'h1, 2'h3, 0, 0);
		result("zeroWidth", 0, 0);
		pulseCycles <= 16'h0008;
		drive(2'h0, 2'h3, 0, 4);
		drive(2'h1, 2'h3, 0, 5);
		// reset cuts the pulse; trigger still true after release
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		result("midReset", 2, 1);
		final_report;
	end
endmodule
